// File: dscp_port.v
// Serial command port with register file and output span decode
// Notes on behaviour
// - Forbidden span code keeps previous span
// - Span change reloads converter data with clear
// - Overrange bit widens voltage spans ten percent
// - Dual mode: span 1xx disables voltage output
// - Current span: off, 4-20, 0-20, 0-24
// - Frame: address byte, then data word
// - MSB first, one bit per rising edge
// - Shift always; commit on every strobe rise
// - Shift register clears to zero on reset
// - Address 00 no-op, 01 writes data
// - 55 control, 56 reset, 57 configuration
// - 58 gain, 59 zero, 95 watchdog restart
// - Read: request frame, then answer frame
// - Read selector is data bits 5..0
// - Readback MSB first on falling edges
// - Low bits 00/01/10: status/data/control
// - 001011 config, 010011 gain, 010111 zero
// - Single mode span code table
// - Twelve-bit variant uses bits 15..4
`timescale 1ns/1ps
`include "dscp_regs.vh"

module dscp_port #(
	parameter TWELVE_BIT = 0
) (
	input wire sys_clk_in,
	input wire srst_in,
	input wire sclk_in,
	input wire sdi_in,
	input wire latch_in,
	input wire clear_value_select_in,
	input wire [15:0] fault_flags_in,
	output reg sdo_out,
	output reg voltage_output_en_out,
	output reg current_output_en_out,
	output reg span_extend_ten_percent_out,
	output reg [3:0] voltage_span_out,
	output reg [3:0] current_span_out,
	output reg [15:0] converter_data_out,
	output reg [15:0] control_settings_out,
	output reg [15:0] configuration_settings_out,
	output reg [15:0] gain_trim_out,
	output reg [15:0] zero_trim_out,
	output reg soft_reset_out,
	output reg watchdog_restart_out
);

////////////////////////////////////////////////////////////////////////////////
// Synchronisers for the pins
// Every pin comes from the host's domain, so each one passes two flops before
// any logic reads it. The serial clock is only sampled, never used as a clock:
// the host must hold each level for at least three system clocks, which caps
// the serial rate well below the pin's own limit. That was traded for a
// design with a single clock domain and no crossing of data words.
wire [3:0] pin_raw;
wire [3:0] pin_idle = `DSCP_PIN_IDLE;
wire [3:0] pin_sync;
genvar gi;

assign pin_raw[`DSCP_PIN_SCLK] = sclk_in;
assign pin_raw[`DSCP_PIN_SDI] = sdi_in;
assign pin_raw[`DSCP_PIN_LATCH] = latch_in;
assign pin_raw[`DSCP_PIN_CLRSEL] = clear_value_select_in;

// One two-stage chain per pin; only the second stage is read
generate
	for (gi = 0; gi < `DSCP_NUM_PINS; gi = gi + 1) begin : g_sync
		reg meta_q;
		reg stable_q;
		always @(posedge sys_clk_in) begin
			if (srst_in) begin
				// Idle level, so no false edge follows reset
				meta_q <= pin_idle[gi];
				stable_q <= pin_idle[gi];
			end else begin
				meta_q <= pin_raw[gi];
				stable_q <= meta_q;
			end
		end
		assign pin_sync[gi] = stable_q;
	end
endgenerate

wire sclk_s = pin_sync[`DSCP_PIN_SCLK];
wire sdi_s = pin_sync[`DSCP_PIN_SDI];
wire latch_s = pin_sync[`DSCP_PIN_LATCH];
wire clrsel_s = pin_sync[`DSCP_PIN_CLRSEL];

// Edge detectors on the synchronised clock and strobe
reg sclk_last_q, latch_last_q;
wire sclk_rise = sclk_s & ~sclk_last_q;
wire sclk_fall = ~sclk_s & sclk_last_q;
wire latch_rise = latch_s & ~latch_last_q;

always @(posedge sys_clk_in) begin
	if (srst_in) begin
		sclk_last_q <= pin_idle[`DSCP_PIN_SCLK];
		latch_last_q <= pin_idle[`DSCP_PIN_LATCH];
	end else begin
		sclk_last_q <= sclk_s;
		latch_last_q <= latch_s;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Input shift register; a strobe rise only copies, never gates shifting
reg [23:0] shift_q;
wire [7:0] addr = shift_q[`DSCP_ADDR_HI:`DSCP_ADDR_LO];
wire [15:0] word = shift_q[`DSCP_DATA_HI:0];
// Low nibble dropped on the twelve-bit part
wire [15:0] word_m = TWELVE_BIT ? (word & `DSCP_LOW_NIBBLE) : word;

always @(posedge sys_clk_in) begin
	if (srst_in) begin
		shift_q <= `DSCP_ZERO24;
	end else if (sclk_rise) begin
		// Data is sampled in the cycle the rise is seen; both took the same path
		shift_q <= {shift_q[`DSCP_FRAME_BITS-2:0], sdi_s};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Span decode of the written control word
wire [2:0] new_span = word[`DSCP_SPAN_HI:0];
wire span_bad = (new_span == `DSCP_SPAN_BAD);
wire [2:0] cur_span = control_settings_out[`DSCP_SPAN_HI:0];
wire span_change = !span_bad && (new_span != cur_span);
// Clear value: pin or bit select; midscale for unipolar voltage, zero otherwise
// Bipolar spans clear to code zero, the negative end of the range
wire clear_value_select = clrsel_s | word[`DSCP_CLRSEL_BIT];
wire [15:0] clear_val = (clear_value_select && (new_span[2:1] == 2'h0)) ? `DSCP_MID16 : `DSCP_ZERO16;

////////////////////////////////////////////////////////////////////////////////
// Commit: write decode and read request capture
// The selector is taken straight from the request frame, so the answer is
// ready at its own commit and can leave in the very next frame
wire [5:0] rd_sel = word[`DSCP_SEL_HI:0];
reg [15:0] rd_word;

// Full selector codes win over the two-bit short codes
always @* begin
	rd_word = `DSCP_ZERO16;
	if (rd_sel == `DSCP_RSEL_CONF)
		rd_word = configuration_settings_out;
	else if (rd_sel == `DSCP_RSEL_GAIN)
		rd_word = gain_trim_out;
	else if (rd_sel == `DSCP_RSEL_ZERO)
		rd_word = zero_trim_out;
	else begin
		case (rd_sel[1:0])
			`DSCP_RSEL_STAT: rd_word = fault_flags_in;
			`DSCP_RSEL_DATA: rd_word = converter_data_out;
			`DSCP_RSEL_CTRL: rd_word = control_settings_out;
			default: rd_word = `DSCP_ZERO16;
		endcase
	end
end

always @(posedge sys_clk_in) begin
	if (srst_in) begin
		converter_data_out <= `DSCP_ZERO16;
		control_settings_out <= `DSCP_ZERO16;
		configuration_settings_out <= `DSCP_ZERO16;
		gain_trim_out <= `DSCP_ZERO16;
		zero_trim_out <= `DSCP_ZERO16;
		soft_reset_out <= 1'b0;
		watchdog_restart_out <= 1'b0;
	end else begin
		soft_reset_out <= 1'b0;
		watchdog_restart_out <= 1'b0;
		// Commit copies whatever the shift register holds; no frame check here
		if (latch_rise) begin
			case (addr)
				`DSCP_ADDR_NOP: ;
				`DSCP_ADDR_DATA: converter_data_out <= word_m;
				// Read request changes no register; the readback shifter acts
				`DSCP_ADDR_READ: ;
				`DSCP_ADDR_CTRL: begin
					if (span_bad)
						control_settings_out <= {word[15:3], cur_span};
					else
						control_settings_out <= word;
					if (span_change)
						converter_data_out <= clear_val;
				end
				`DSCP_ADDR_SRST: soft_reset_out <= word[`DSCP_RST_BIT];
				`DSCP_ADDR_CONF: configuration_settings_out <= word;
				`DSCP_ADDR_GAIN: gain_trim_out <= word_m;
				`DSCP_ADDR_ZERO: zero_trim_out <= word_m;
				`DSCP_ADDR_WDOG: watchdog_restart_out <= 1'b1;
				default: ;
			endcase
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Readback shifter, loaded at the commit of a read request
reg [23:0] out_q;

always @(posedge sys_clk_in) begin
	if (srst_in) begin
		out_q <= `DSCP_ZERO24;
		sdo_out <= 1'b0;
	end else if (latch_rise) begin
		// Read request is answered in the following frame; sdo itself is
		// left alone so it only ever moves after a falling serial edge
		if (addr == `DSCP_ADDR_READ)
			out_q <= {addr, rd_word};
		else
			out_q <= `DSCP_ZERO24;
	end else if (sclk_fall) begin
		sdo_out <= out_q[`DSCP_FRAME_BITS-1];
		out_q <= {out_q[`DSCP_FRAME_BITS-2:0], 1'b0};
	end
end

////////////////////////////////////////////////////////////////////////////////
// Output span decode from control and configuration
wire dual = configuration_settings_out[`DSCP_DUAL_BIT];
wire [1:0] ispan = configuration_settings_out[`DSCP_ISPAN_HI:`DSCP_ISPAN_LO];
reg v_en_d;
reg i_en_d;
reg [3:0] v_span_d;
reg [3:0] i_span_d;

// Next values of both outputs; registered below so every pin is a flop
always @* begin
	v_en_d = ~cur_span[`DSCP_SPAN_HI];
	v_span_d = `DSCP_ST_OFF;
	i_en_d = 1'b0;
	i_span_d = `DSCP_ST_OFF;
	// Voltage span codes map onto state codes by a fixed offset
	if (!cur_span[`DSCP_SPAN_HI])
		v_span_d = {2'h0, cur_span[1:0]} + `DSCP_ST_V5;
	if (dual) begin
		// Dual mode: current span comes from configuration only
		i_en_d = (ispan != `DSCP_ISPAN_OFF);
		case (ispan)
			`DSCP_ISPAN_4_20: i_span_d = `DSCP_ST_I4_20;
			`DSCP_ISPAN_0_20: i_span_d = `DSCP_ST_I0_20;
			`DSCP_ISPAN_0_24: i_span_d = `DSCP_ST_I0_24;
			default: i_span_d = `DSCP_ST_OFF;
		endcase
	end else begin
		// Single mode: the upper span codes pick the current output
		i_en_d = cur_span[`DSCP_SPAN_HI];
		case (cur_span)
			`DSCP_SPAN_I4_20: i_span_d = `DSCP_ST_I4_20;
			`DSCP_SPAN_I0_20: i_span_d = `DSCP_ST_I0_20;
			`DSCP_SPAN_I0_24: i_span_d = `DSCP_ST_I0_24;
			default: i_span_d = `DSCP_ST_OFF;
		endcase
	end
end

// Output registers; one cycle behind the control words they follow
always @(posedge sys_clk_in) begin
	if (srst_in) begin
		voltage_output_en_out <= 1'b0;
		current_output_en_out <= 1'b0;
		span_extend_ten_percent_out <= 1'b0;
		voltage_span_out <= `DSCP_ST_OFF;
		current_span_out <= `DSCP_ST_OFF;
	end else begin
		// Overrange only meaningful for voltage spans
		span_extend_ten_percent_out <= control_settings_out[`DSCP_OVR_BIT];
		voltage_output_en_out <= v_en_d;
		voltage_span_out <= v_span_d;
		current_output_en_out <= i_en_d;
		current_span_out <= i_span_d;
	end
end

endmodule

// File: dscp_regs.vh
// Constants for the serial command port: frame layout, addresses, fields, reset values
`ifndef DSCP_REGS_VH
`define DSCP_REGS_VH
`define DSCP_FRAME_BITS 24
`define DSCP_CNT_W 5
`define DSCP_ADDR_HI 23
`define DSCP_ADDR_LO 16
`define DSCP_DATA_HI 15
`define DSCP_ADDR_NOP 8'h00
`define DSCP_ADDR_DATA 8'h01
`define DSCP_ADDR_READ 8'h02
`define DSCP_ADDR_CTRL 8'h55
`define DSCP_ADDR_SRST 8'h56
`define DSCP_ADDR_CONF 8'h57
`define DSCP_ADDR_GAIN 8'h58
`define DSCP_ADDR_ZERO 8'h59
`define DSCP_ADDR_WDOG 8'h95
`define DSCP_SEL_HI 5
`define DSCP_RSEL_STAT 2'h0
`define DSCP_RSEL_DATA 2'h1
`define DSCP_RSEL_CTRL 2'h2
`define DSCP_RSEL_CONF 6'h0b
`define DSCP_RSEL_GAIN 6'h13
`define DSCP_RSEL_ZERO 6'h17
`define DSCP_SPAN_HI 2
`define DSCP_SPAN_BAD 3'h4
`define DSCP_CLRSEL_BIT 15
`define DSCP_OVR_BIT 14
`define DSCP_DUAL_BIT 8
`define DSCP_ISPAN_HI 10
`define DSCP_ISPAN_LO 9
`define DSCP_RST_BIT 0
`define DSCP_SR_BUSY_BIT 1
`define DSCP_LOW_NIBBLE 16'hfff0
`define DSCP_ZERO16 16'h0000
`define DSCP_ZERO24 24'h000000
`define DSCP_MID16 16'h8000
`define DSCP_ISPAN_OFF 2'h0
`define DSCP_ISPAN_4_20 2'h1
`define DSCP_ISPAN_0_20 2'h2
`define DSCP_ISPAN_0_24 2'h3
`define DSCP_ST_OFF 4'h0
`define DSCP_ST_V5 4'h1
`define DSCP_ST_V10 4'h2
`define DSCP_ST_B5 4'h3
`define DSCP_ST_B10 4'h4
`define DSCP_ST_I4_20 4'h5
`define DSCP_ST_I0_20 4'h6
`define DSCP_ST_I0_24 4'h7
`define DSCP_SPAN_I4_20 3'h5
`define DSCP_SPAN_I0_20 3'h6
`define DSCP_SPAN_I0_24 3'h7
`define DSCP_NUM_PINS 4
`define DSCP_PIN_SCLK 0
`define DSCP_PIN_SDI 1
`define DSCP_PIN_LATCH 2
`define DSCP_PIN_CLRSEL 3
`define DSCP_PIN_IDLE 4'h1
`endif

// File: dscp_port_checker.sv
// Checker for the serial command port
`timescale 1ns/1ps
module dscp_port_checker (
	input wire sys_clk_in,
	input wire srst_in,
	input wire sclk_in,
	input wire latch_in,
	input wire sdo_out,
	input wire [3:0] voltage_span_out,
	input wire span_extend_ten_percent_out,
	input wire [15:0] converter_data_out,
	input wire [15:0] control_settings_out,
	input wire [15:0] configuration_settings_out,
	input wire watchdog_restart_out
);
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);
	// Registers move only while the strobe pulse is still high, a few clocks on
	a_data_commit: assert property ($changed(converter_data_out) |-> $past(latch_in, 2))
		else $error("data moved off commit");
	a_ctrl_commit: assert property ($changed(control_settings_out) |-> $past(latch_in, 2))
		else $error("control moved off commit");
	a_reset_clear: assert property ($fell(srst_in) |-> converter_data_out == 16'h0000)
		else $error("data not clear");
	a_wdog_pulse: assert property (watchdog_restart_out |=> !watchdog_restart_out)
		else $error("restart pulse long");
	a_sdo_fall: assert property ($changed(sdo_out) |-> !sclk_in)
		else $error("sdo moved with clock high");
	a_ovr_follow: assert property ($stable(control_settings_out) [*3] |->
		span_extend_ten_percent_out == control_settings_out[14]) else $error("overrange lost");
	a_dual_voff: assert property (
		(configuration_settings_out[8] && control_settings_out[2]) [*3] |-> voltage_span_out == 4'h0)
		else $error("voltage on in dual");
	a_span_clear: assert property ($changed(control_settings_out[2:0]) |->
		##[0:2] converter_data_out inside {16'h0000, 16'h8000}) else $error("no clear on span");
	c_wdog: cover property (watchdog_restart_out);
	c_dual: cover property (configuration_settings_out[8] && voltage_span_out == 4'h0);
	c_sdo: cover property (sdo_out);
endmodule
bind dscp_port dscp_port_checker dscp_port_checker_inst (.*);

// File: dscp_host.sv
// Host model driving serial frames
`timescale 1ns/1ps
module dscp_host (
	input wire sys_clk_in,
	input wire sdo_in,
	output reg sclk_out = 1'b1,
	output reg sdi_out = 1'b0,
	output reg latch_out = 1'b0
);
	// Wait n clocks, then step just past the edge
	task tick(input integer n);
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask
	// Clock idles high, so every bit gets a fall before its rise; 64 ns period
	task frame(input [23:0] tx, output [23:0] rx);
		integer i;
		for (i = 23; i >= 0; i = i - 1) begin
			sclk_out = 1'b0;
			sdi_out = tx[i];
			tick(4);
			rx[i] = sdo_in;
			sclk_out = 1'b1;
			tick(4);
		end
		// Released data line flips, never a stale bit
		sdi_out = ~sdi_out;
		latch_out = 1'b1;
		tick(4);
		latch_out = 1'b0;
		tick(8);
	endtask
endmodule

// File: dscp_port_bench.sv
// Self-checking bench for the serial command port
`timescale 1ns/1ps
module dscp_port_bench;
	reg sys_clk_in = 1'b0;
	reg srst_in = 1'b1;
	wire sclk_in, sdi_in, latch_in, sdo_out, soft_reset_out, watchdog_restart_out;
	wire span_extend_ten_percent_out;
	wire [3:0] voltage_span_out, current_span_out;
	wire [15:0] converter_data_out, control_settings_out, configuration_settings_out;
	wire [15:0] gain_trim_out, zero_trim_out;
	integer fails = 0, n_compared = 0, cyc = 0, pulses = 0, s;
	reg [23:0] rx;
	reg [3:0] v;
	dscp_port dscp_port_inst (.clear_value_select_in(1'b0), .fault_flags_in(16'h00a5),
		.voltage_output_en_out(), .current_output_en_out(), .*);
	dscp_host dscp_host_inst (.sys_clk_in(sys_clk_in), .sdo_in(sdo_out), .sclk_out(sclk_in),
		.sdi_out(sdi_in), .latch_out(latch_in));
	initial forever #4 sys_clk_in = ~sys_clk_in;
	// Cycle ceiling and tally of one-cycle pulses
	always @(posedge sys_clk_in) begin
		cyc = cyc + 1;
		if (!srst_in)
			pulses = pulses + soft_reset_out + watchdog_restart_out;
		if (cyc == 15000) begin
			fails = fails + 1;
			summarize;
		end
	end
	task summarize;
		$display("compared %0d failed %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input [47:0] got, input [47:0] exp);
		n_compared = n_compared + 1;
		if (got !== exp) begin
			fails = fails + 1;
			$display("Error at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task wr(input [7:0] a, input [15:0] d);
		dscp_host_inst.frame({a, d}, rx);
	endtask
	// Request with junk in the upper data bits, then a no-op that returns the value
	task rd(input [5:0] sel, input [15:0] exp);
		wr(8'h02, {10'h3ff, sel});
		wr(8'h00, 16'h0000);
		chk(rx, {8'h02, exp});
	endtask
	initial begin
		dscp_host_inst.tick(10);
		srst_in = 1'b0;
		dscp_host_inst.tick(4);
		wr(8'h01, 16'h1234);
		wr(8'h00, 16'hffff);
		wr(8'h33, 16'hffff);
		chk({converter_data_out, control_settings_out}, 32'h12340000);
		wr(8'h55, 16'h4001);
		chk({converter_data_out, voltage_span_out, span_extend_ten_percent_out}, 21'h5);
		wr(8'h55, 16'h8000);
		chk({converter_data_out, voltage_span_out}, 20'h80001);
		// Every span code; the forbidden one keeps the previous span
		for (s = 0; s < 8; s = s + 1) begin
			wr(8'h55, s[15:0]);
			v = s < 4 ? s[3:0] + 4'h1 : s == 4 ? 4'h4 : 4'h0;
			chk({voltage_span_out, current_span_out}, {v, s > 4 ? s[3:0] : 4'h0});
		end
		for (s = 0; s < 4; s = s + 1) begin
			wr(8'h57, {5'h0, s[1:0], 9'h100});
			chk({voltage_span_out, current_span_out}, s == 0 ? 0 : s + 4);
		end
		wr(8'h55, 16'h0001);
		wr(8'h01, 16'hbeef);
		wr(8'h58, 16'h8001);
		wr(8'h59, 16'hfffe);
		rd(6'h3d, 16'hbeef);
		rd(6'h3e, 16'h0001);
		rd(6'h0b, 16'h0700);
		rd(6'h13, 16'h8001);
		rd(6'h17, 16'hfffe);
		rd(6'h3c, 16'h00a5);
		wr(8'h95, 16'h0000);
		wr(8'h56, 16'h0001);
		chk(pulses, 2);
		summarize;
	end
endmodule
